//--- core/fpwm_core.sv
// Flyback PWM control law and fault qualification core
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: Start above 15.3 V turn-on, run until 9 V, 28 V ceiling.
// RULE2: Peak current threshold confined between 200 mV and 900 mV.
// RULE3: Threshold equals control voltage minus 0.8 V, divided by two.
// RULE4: Current comparison blanked 250 ns after each gate turn-on.
// RULE5: Current above 900 mV during blanking marks a short-circuit pulse.
// RULE6: Fault pin below 0.5 V stops switching in every variant.
// RULE7: Leaving the disabled state happens at once when pin rises.
// RULE8: Brown-out stop only after pin low continuously over 45 ms.
// RULE9: Brown-out recovery resumes switching immediately, no supply restart.
// RULE10: Overvoltage fault after three consecutive cycles above its level.
// RULE11: Overtemperature fault after 32 cycles below 1.0 V.
// RULE12: Brown-out variant sources no pin current at startup.
// RULE13: Control voltage is lower of soft-start ramp and feedback.
// RULE14: Soft-start ramp takes 4.3 ms from start to full value.
// RULE15: Boost region raises frequency, holds threshold at 900 mV.
// RULE16: Normal region fixed frequency, only threshold follows load.
// RULE17: Foldback region lowers frequency and threshold with feedback.
// RULE18: Between 1.1 V and 1.2 V use lowest threshold and frequency.
// RULE19: Below burst stop level cease switching, restart when above.
// RULE20: Undervoltage stops at once; supply overvoltage after three cycles.
// RULE21: Auto-restart retries each startup cycle, faults clear on retry.
// RULE22: Qualification counters clear when their condition drops early.
// RULE23: Gate held low under fault, disable, lockout or burst stop.
module fpwm_core
   import fpwm_pkg::*;
#(
   parameter int unsigned SS_CYCLES = SS_CYC_DEF,
   parameter int unsigned BO_CYCLES = BO_CYC_DEF,
   parameter bit BO_VARIANT = 1'b1,
   parameter bit FAST_VARIANT = 1'b0
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   // Analog front end results, asynchronous
   input wire fpwm_cmp_t cmp_raw,
   input wire logic [MV_W-1:0] feedback_input,
   input wire logic [MV_W-1:0] cs_sense_mv,
   // Power stage and status
   output logic gate_drive_output,
   output logic fault_offset_en,
   output fpwm_stat_t status
);

   // ==========================================================
   // Elaboration checks
   localparam int unsigned SS_STEP_CYC = SS_CYCLES / SS_STEPS;
   generate
      if (SS_STEP_CYC < 1 || SS_STEP_CYC > 24'hFFFFFF) begin : g_bad_ss
         $error("soft-start length out of range");
      end
      if (BO_CYCLES < 1 || BO_CYCLES > 24'hFFFFFE) begin : g_bad_bo
         $error("brown-out length out of range");
      end
   endgenerate

   localparam logic [13:0] PER_NORM =
      FAST_VARIANT ? PER_NORM_FAST : PER_NORM_SLOW;
   localparam logic [13:0] PER_BOOST =
      FAST_VARIANT ? PER_BOOST_FAST : PER_BOOST_SLOW;
   localparam logic [13:0] FOLD_K =
      14'((PER_MIN_F - PER_NORM) / (FOLD_ENTRY_MV - BURST_ENTRY_MV));
   localparam logic [23:0] SS_STEP_N = 24'(SS_STEP_CYC);
   localparam logic [23:0] BO_N = 24'(BO_CYCLES);
   localparam logic [12:0] SS_INC = 13'(SS_FULL_MV / SS_STEPS);
   localparam logic [7:0] LEB_N = 8'(LEB_CYC);

   // ==========================================================
   // Two-flop synchronisers; words assumed slow against the clock
   fpwm_cmp_t cmp_m_q, cmp_s_q;
   logic [MV_W-1:0] fb_m_q, fb_s_q, cs_m_q, cs_s_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cmp_m_q <= '0;
         cmp_s_q <= '0;
         fb_m_q <= '0;
         fb_s_q <= '0;
         cs_m_q <= '0;
         cs_s_q <= '0;
      end else if (ce) begin
         cmp_m_q <= cmp_raw;
         cmp_s_q <= cmp_m_q;
         fb_m_q <= feedback_input;
         fb_s_q <= fb_m_q;
         cs_m_q <= cs_sense_mv;
         cs_s_q <= cs_m_q;
      end
   end

   // ==========================================================
   // State
   logic run_q;
   logic flt_q;
   logic offset_q;
   logic gate_q;
   logic sc_seen_q;
   logic [PER_W-1:0] cnt_q, per_q, dmax_q;
   logic [MV_W-1:0] thr_q, ss_q;
   logic [7:0] leb_q;
   logic [1:0] ovlo_cnt_q, ovp_cnt_q;
   logic [5:0] tsd_cnt_q;
   logic [3:0] sc_cnt_q;
   logic [23:0] bo_cnt_q, ss_div_q;

   // ==========================================================
   // Protection decode
   wire disabled_w = cmp_s_q.flt_below_dis; // RULE6 RULE7
   wire bo_stop_w = BO_VARIANT && (bo_cnt_q > BO_N); // RULE8 RULE9
   wire burst_stop_w = fb_s_q < BURST_STOP_MV; // RULE19
   wire ovp_on_w = !BO_VARIANT && cmp_s_q.flt_above_ovp;
   wire tsd_on_w = !BO_VARIANT && cmp_s_q.flt_below_tsd;
   wire cyc_end_w = (cnt_q >= per_q - 14'h0001);
   // Gate may run only with every stop condition clear
   wire sw_ok_w = run_q && !flt_q && !disabled_w && !bo_stop_w
      && !burst_stop_w; // RULE23
   wire restart_w = !run_q || flt_q; // RULE21

   // Trip points of each qualification counter
   wire ovlo_trip_w = cmp_s_q.vdd_above_ovlo
      && (ovlo_cnt_q == OVLO_CYCLES - 2'h1); // RULE20
   wire ovp_trip_w = ovp_on_w && (ovp_cnt_q == OVP_CYCLES - 2'h1);
   wire tsd_trip_w = tsd_on_w && (tsd_cnt_q == TSD_CYCLES - 6'h01);
   wire sc_trip_w = sc_seen_q && (sc_cnt_q == SC_CYCLES - 4'h1);
   wire any_trip_w = cyc_end_w
      && (ovlo_trip_w || ovp_trip_w || tsd_trip_w || sc_trip_w);

   // ==========================================================
   // Control voltage, region and threshold
   wire [MV_W-1:0] vctrl_w = (ss_q < fb_s_q) ? ss_q : fb_s_q; // RULE13
   wire boost_w = vctrl_w >= BOOST_ENTRY_MV;
   wire fold_w = vctrl_w < FOLD_ENTRY_MV;
   wire lowest_w = vctrl_w < BURST_ENTRY_MV; // RULE18
   wire [MV_W-1:0] raw_thr_w = (vctrl_w > FB_OFFSET_MV) ?
      ((vctrl_w - FB_OFFSET_MV) >> 1) : '0; // RULE3
   wire [MV_W-1:0] clamp_thr_w = (raw_thr_w < CS_MIN_MV) ? CS_MIN_MV :
      (raw_thr_w > CS_LIMIT_MV) ? CS_LIMIT_MV : raw_thr_w; // RULE2
   // Boost pins the limit, the lowest band pins the floor
   wire [MV_W-1:0] thr_d = boost_w ? CS_LIMIT_MV :
      lowest_w ? CS_MIN_MV : clamp_thr_w; // RULE15 RULE18

   // Period rises linearly through foldback down to the 25 kHz floor
   wire [MV_W-1:0] fold_diff_w = FOLD_ENTRY_MV - vctrl_w;
   wire [27:0] fold_per_w = 28'(PER_NORM) + 28'(fold_diff_w) * 28'(FOLD_K);
   wire [PER_W-1:0] fold_cap_w = (fold_per_w > 28'(PER_MIN_F)) ?
      PER_MIN_F : fold_per_w[PER_W-1:0]; // RULE17
   wire [PER_W-1:0] per_d = boost_w ? PER_BOOST : // RULE15
      lowest_w ? PER_MIN_F : // RULE18
      fold_w ? fold_cap_w : PER_NORM; // RULE16
   wire [PER_W-1:0] dmax_d = per_d - PER_W'(per_d / 14'h0005);

   // ==========================================================
   // Pulse termination terms
   wire leb_on_w = leb_q < LEB_N; // RULE4
   wire cs_trip_w = !leb_on_w && (cs_s_q >= thr_q);
   wire sc_pulse_w = gate_q && leb_on_w && (cs_s_q > CS_LIMIT_MV); // RULE5

   // ==========================================================
   // Supply lockout and latched auto-restart fault
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         run_q <= 1'b0;
         flt_q <= 1'b0;
         offset_q <= 1'b0;
      end else if (ce) begin
         if (!run_q && cmp_s_q.vdd_above_on)
            run_q <= 1'b1; // RULE1
         else if (cmp_s_q.vdd_below_off)
            run_q <= 1'b0; // RULE1 RULE20
         // Supply collapse is the retry cycle that clears the fault
         if (run_q && any_trip_w)
            flt_q <= 1'b1;
         else if (!run_q)
            flt_q <= 1'b0; // RULE21
         // Offset current only after brown-in, never at startup
         if (!run_q)
            offset_q <= 1'b0; // RULE12
         else if (BO_VARIANT && !cmp_s_q.flt_below_bo)
            offset_q <= 1'b1;
      end
   end

   // ==========================================================
   // Cycle-qualified fault counters, cleared on early release
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ovlo_cnt_q <= '0;
         ovp_cnt_q <= '0;
         tsd_cnt_q <= '0;
         sc_cnt_q <= '0;
      end else if (ce && (restart_w || cyc_end_w)) begin
         if (restart_w) begin
            ovlo_cnt_q <= '0;
            ovp_cnt_q <= '0;
            tsd_cnt_q <= '0;
            sc_cnt_q <= '0;
         end else begin
            ovlo_cnt_q <= cmp_s_q.vdd_above_ovlo ?
               ovlo_cnt_q + 2'h1 : '0; // RULE20 RULE22
            ovp_cnt_q <= ovp_on_w ? ovp_cnt_q + 2'h1 : '0; // RULE10 RULE22
            tsd_cnt_q <= tsd_on_w ? tsd_cnt_q + 6'h01 : '0; // RULE11 RULE22
            sc_cnt_q <= sc_seen_q ? sc_cnt_q + 4'h1 : '0; // RULE22
         end
      end
   end

   // ==========================================================
   // Brown-out timer on the clock; saturates one past the limit
   always_ff @(posedge ref_clk) begin
      if (!resetn)
         bo_cnt_q <= '0;
      else if (ce) begin
         if (!cmp_s_q.flt_below_bo)
            bo_cnt_q <= '0; // RULE9 RULE22
         else if (bo_cnt_q <= BO_N)
            bo_cnt_q <= bo_cnt_q + 24'h000001; // RULE8
      end
   end

   // ==========================================================
   // Stepped ramp, restarted each startup; last step lands on full value
   wire [MV_W-1:0] ss_next_w = (ss_q + SS_INC > SS_FULL_MV - SS_INC) ?
      SS_FULL_MV : ss_q + SS_INC; // RULE14
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ss_q <= '0;
         ss_div_q <= '0;
      end else if (ce) begin
         if (restart_w) begin
            ss_q <= '0;
            ss_div_q <= '0;
         end else if (ss_q < SS_FULL_MV) begin
            if (ss_div_q == SS_STEP_N - 24'h000001) begin
               ss_div_q <= '0;
               ss_q <= ss_next_w; // RULE14
            end else
               ss_div_q <= ss_div_q + 24'h000001;
         end
      end
   end

   // ==========================================================
   // Switching cycle: period counter, gate and blanking
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_q <= '0;
         per_q <= PER_NORM;
         dmax_q <= '0;
         thr_q <= CS_MIN_MV;
         gate_q <= 1'b0;
         leb_q <= '0;
         sc_seen_q <= 1'b0;
      end else if (ce) begin
         if (cyc_end_w) begin
            cnt_q <= '0;
            per_q <= per_d;
            dmax_q <= dmax_d;
            thr_q <= thr_d;
            gate_q <= sw_ok_w && !any_trip_w; // RULE23
            leb_q <= '0;
            sc_seen_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 14'h0001;
            if (leb_on_w)
               leb_q <= leb_q + 8'h01;
            if (sc_pulse_w)
               sc_seen_q <= 1'b1; // RULE5
            // Noise inside blanking cannot end the pulse
            if (!sw_ok_w || cs_trip_w || cnt_q >= dmax_q)
               gate_q <= 1'b0; // RULE4 RULE23
         end
      end
   end

   // ==========================================================
   // Registered outputs
   fpwm_stat_t stat_d;
   assign stat_d = '{running: run_q, disabled: disabled_w,
      brownout: bo_stop_w, fault: flt_q, burst_stop: burst_stop_w};
   assign gate_drive_output = gate_q;
   assign fault_offset_en = offset_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn)
         status <= '0;
      else if (ce)
         status <= stat_d;
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_gate_stops;
      (ce && !sw_ok_w) |=> !gate_q;
   endproperty
   a_gate_stops: assert property (p_gate_stops) // RULE23
      else $error("gate high while stopped");
   property p_thr_range;
      thr_q >= CS_MIN_MV && thr_q <= CS_LIMIT_MV;
   endproperty
   a_thr_range: assert property (p_thr_range) // RULE2
      else $error("threshold out of range");
   property p_thr_calc;
      (!boost_w && !lowest_w && raw_thr_w >= CS_MIN_MV
         && raw_thr_w <= CS_LIMIT_MV)
      |-> 13'(2 * thr_d + FB_OFFSET_MV) >= vctrl_w - 13'h0001
         && 13'(2 * thr_d + FB_OFFSET_MV) <= vctrl_w;
   endproperty
   a_thr_calc: assert property (p_thr_calc) // RULE3
      else $error("threshold not derived from control voltage");
   property p_leb_hold;
      (ce && gate_q && leb_on_w && sw_ok_w && !cyc_end_w
         && cnt_q < dmax_q) |=> gate_q;
   endproperty
   a_leb_hold: assert property (p_leb_hold) // RULE4
      else $error("pulse ended inside blanking");
   property p_disable;
      (ce && cmp_s_q.flt_below_dis) |=> !gate_q;
   endproperty
   a_disable: assert property (p_disable) // RULE6
      else $error("gate high while disabled");
   property p_ovp_count;
      $rose(flt_q) |-> $past(ovlo_cnt_q) == 2'h2
         || $past(ovp_cnt_q) == 2'h2 || $past(tsd_cnt_q) == 6'h1F
         || $past(sc_cnt_q) == 4'h7;
   endproperty
   a_ovp_count: assert property (p_ovp_count) // RULE10
      else $error("fault latched without full qualification");
   property p_tsd_clear;
      (ce && !restart_w && cyc_end_w && !tsd_on_w) |=> tsd_cnt_q == 6'h00;
   endproperty
   a_tsd_clear: assert property (p_tsd_clear) // RULE22
      else $error("overtemperature counter not cleared");
   property p_burst;
      (ce && fb_s_q < BURST_STOP_MV) |=> !gate_q;
   endproperty
   a_burst: assert property (p_burst) // RULE19
      else $error("switching below burst stop level");
   property p_start;
      $rose(run_q) |-> $past(cmp_s_q.vdd_above_on);
   endproperty
   a_start: assert property (p_start) // RULE1
      else $error("started without turn-on level");
   property p_vctrl;
      vctrl_w <= fb_s_q && vctrl_w <= ss_q;
   endproperty
   a_vctrl: assert property (p_vctrl) // RULE13
      else $error("control voltage not the lower input");
   property p_offset;
      (ce && !run_q) |=> !offset_q;
   endproperty
   a_offset: assert property (p_offset) // RULE12
      else $error("offset current before start");
   c_pulse: cover property (ce && $rose(gate_q));
   c_fault: cover property ($rose(flt_q));
   c_brownout: cover property ($rose(bo_stop_w));
   c_boost: cover property (cyc_end_w && boost_w && sw_ok_w);

endmodule

`default_nettype wire

//--- include/fpwm_pkg.sv
// Constants and carrier types of the flyback PWM control core
package fpwm_pkg;

   // ==========================================================
   // Clock and widths
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
   localparam int unsigned MV_W = 13;
   localparam int unsigned PER_W = 14;

   // ==========================================================
   // Levels in millivolts
   localparam logic [12:0] FB_OFFSET_MV = 13'h0320;  // 800 mV
   localparam logic [12:0] CS_MIN_MV = 13'h00C8;     // 200 mV
   localparam logic [12:0] CS_LIMIT_MV = 13'h0384;   // 900 mV
   localparam logic [12:0] BURST_ENTRY_MV = 13'h04B0; // 1200 mV
   localparam logic [12:0] BURST_STOP_MV = 13'h044C;  // 1100 mV
   localparam logic [12:0] FOLD_ENTRY_MV = 13'h07D0;  // 2000 mV
   localparam logic [12:0] BOOST_ENTRY_MV = 13'h0BB8; // 3000 mV
   localparam logic [12:0] SS_FULL_MV = 13'h1388;     // 5000 mV
   localparam int unsigned SS_STEPS = 16;

   // ==========================================================
   // Switching frequencies in kHz and derived periods
   localparam int unsigned F_NORM_SLOW_KHZ = 65;
   localparam int unsigned F_NORM_FAST_KHZ = 100;
   localparam int unsigned F_MIN_KHZ = 25;
   localparam logic [13:0] PER_NORM_SLOW = 14'(CLK_KHZ / F_NORM_SLOW_KHZ);
   localparam logic [13:0] PER_NORM_FAST = 14'(CLK_KHZ / F_NORM_FAST_KHZ);
   localparam logic [13:0] PER_MIN_F = 14'(CLK_KHZ / F_MIN_KHZ);
   localparam logic [13:0] PER_BOOST_SLOW = 14'(CLK_KHZ / (2 * 65));
   localparam logic [13:0] PER_BOOST_FAST = 14'(CLK_KHZ / (2 * 100));

   // ==========================================================
   // Times and cycle counts
   localparam int unsigned LEB_NS = 250;
   localparam int unsigned LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SS_US = 4300;
   localparam int unsigned SS_CYC_DEF = SS_US * CLK_MHZ;
   localparam int unsigned BO_US = 45000;
   localparam int unsigned BO_CYC_DEF = BO_US * CLK_MHZ;
   localparam logic [1:0] OVLO_CYCLES = 2'h3;
   localparam logic [1:0] OVP_CYCLES = 2'h3;
   localparam logic [5:0] TSD_CYCLES = 6'h20;
   localparam logic [3:0] SC_CYCLES = 4'h8;

   // ==========================================================
   // Comparator results from the analog front end
   typedef struct packed {
      logic vdd_above_on;   // above 15.3 V turn-on
      logic vdd_below_off;  // below 9 V turn-off
      logic vdd_above_ovlo; // above 28 V ceiling
      logic flt_below_dis;  // fault_pin below disable_level
      logic flt_below_bo;   // fault_pin below brown-out level
      logic flt_above_ovp;  // above fault_overvoltage_level
      logic flt_below_tsd;  // below fault_overtemp_level
   } fpwm_cmp_t;

   // Status word
   typedef struct packed {
      logic running;
      logic disabled;
      logic brownout;
      logic fault;
      logic burst_stop;
   } fpwm_stat_t;

endpackage

//--- test/flyback_pwm_control_law_tb_top.sv
// Self-checking bench of the flyback PWM control core
`timescale 1ns/10ps
`default_nettype none
module flyback_pwm_control_law_tb_top
   import fpwm_pkg::*;
;
   // ==========================================================
   // Shortened counts keep the run brief
   localparam int SS_N = 6400;
   localparam int BO_N = 20;
   localparam int SLOPE = 10;

   logic ref_clk, resetn, short_en, gate_a, gate_b, offs_a;
   fpwm_cmp_t cmp;
   fpwm_stat_t stat_a;
   logic [MV_W-1:0] fb, cs_a, cs_b;
   int n_fail, checks_done, seed, w, p, k;

   // ==========================================================
   // Brown-out variant under test, overvoltage variant beside it
   fpwm_core #(.SS_CYCLES(SS_N), .BO_CYCLES(BO_N)) dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .cmp_raw(cmp),
      .feedback_input(fb), .cs_sense_mv(cs_a), .gate_drive_output(gate_a),
      .fault_offset_en(offs_a), .status(stat_a)
   );
   fpwm_core #(.SS_CYCLES(SS_N), .BO_CYCLES(BO_N), .BO_VARIANT(1'b0))
   dut_ov (
      .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .cmp_raw(cmp),
      .feedback_input(fb), .cs_sense_mv(cs_b), .gate_drive_output(gate_b),
      .fault_offset_en(), .status()
   );
   fpwm_plant #(.SLOPE_MV(SLOPE)) pl_a (
      .ref_clk(ref_clk), .gate(gate_a), .short_en(short_en), .cs_mv(cs_a)
   );
   fpwm_plant #(.SLOPE_MV(SLOPE)) pl_b (
      .ref_clk(ref_clk), .gate(gate_b), .short_en(1'b0), .cs_mv(cs_b)
   );

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Reference model of period and on-time from feedback level
   function automatic int m_per(int v);
      if (v >= int'(BOOST_ENTRY_MV)) return int'(PER_BOOST_SLOW);
      if (v >= int'(FOLD_ENTRY_MV)) return int'(PER_NORM_SLOW);
      if (v < int'(BURST_ENTRY_MV)) return int'(PER_MIN_F);
      v = int'(PER_NORM_SLOW) + (int'(FOLD_ENTRY_MV) - v) * 6;
      return v > int'(PER_MIN_F) ? int'(PER_MIN_F) : v;
   endfunction

   function automatic int m_wid(int v);
      int t;
      t = (v - int'(FB_OFFSET_MV)) / 2;
      t = v >= int'(BOOST_ENTRY_MV) ? int'(CS_LIMIT_MV) : t;
      t = v < int'(BURST_ENTRY_MV) ? int'(CS_MIN_MV) : t;
      t = t < int'(CS_MIN_MV) ? int'(CS_MIN_MV) : t;
      t = t > int'(CS_LIMIT_MV) ? int'(CS_LIMIT_MV) : t;
      t = (t + SLOPE - 1) / SLOPE;
      return t < LEB_CYC ? LEB_CYC : t;
   endfunction

   // ==========================================================
   // Comparisons and verdict
   task automatic chk_num(input string s, input logic [31:0] got,
                          input int lo, input int hi);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_fail++;
         $display("BAD %0t %s got %0d", $time, s, got);
      end
   endtask

   task automatic chk_bit(input string s, input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %b", $time, s, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Gate observers, bounded so a dead gate cannot hang the run
   task automatic wait_lvl(input logic b, input logic v, output int n);
      n = 0;
      while ((b ? gate_b : gate_a) !== v && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   task automatic next_rise(input logic b);
      int n;
      wait_lvl(b, 1'b0, n);
      wait_lvl(b, 1'b1, n);
   endtask

   task automatic meas(output int wid, output int per);
      int n;
      next_rise(1'b0);
      wait_lvl(1'b0, 1'b0, wid);
      wait_lvl(1'b0, 1'b1, n);
      per = wid + n;
   endtask

   task automatic rises(input int cyc, output int ra, output int rb);
      logic pa, pb;
      ra = 0;
      rb = 0;
      pa = gate_a;
      pb = gate_b;
      repeat (cyc) begin
         @(negedge ref_clk);
         ra += int'(gate_a & !pa);
         rb += int'(gate_b & !pb);
         pa = gate_a;
         pb = gate_b;
      end
   endtask

   // Feedback step, then one full cycle against the model
   task automatic region(input int v);
      @(posedge ref_clk);
      fb <= v[MV_W-1:0];
      repeat (4) @(negedge ref_clk);
      meas(w, p);
      chk_num("pulse width", w, m_wid(v), m_wid(v) + 6);
      chk_num("period", p, m_per(v), m_per(v));
      $display("test done: region %0d mV", v);
   endtask

   // Watchdog well above the expected run length
   initial begin
      repeat (200000) @(posedge ref_clk);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 81550;
      n_fail = 0;
      checks_done = 0;
      resetn = 1'b0;
      short_en = 1'b0;
      cmp = '0;
      fb = 13'h0DAC;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      rises(300, k, p);
      chk_num("start without supply", k, 0, 0);
      chk_bit("offset at startup", offs_a, 1'b0);
      @(posedge ref_clk);
      cmp.vdd_above_on <= 1'b1;
      cmp.vdd_below_off <= 1'b0;
      meas(w, p);
      chk_num("ramp first width", w, LEB_CYC, m_wid(3500) - 10);
      repeat (8) @(negedge ref_clk);
      chk_bit("running", stat_a.running, 1'b1);
      chk_bit("offset after brown-in", offs_a, 1'b1);
      $display("test done: start-up");
      region(3500);
      for (k = 0; k < 2; k++) begin
         region(2000 + (($random(seed) & 32'h000003FF) % 1000));
      end
      region(1800);
      region(1150);
      // Burst stop and recovery
      @(posedge ref_clk);
      fb <= 13'h03E8;
      repeat (4) @(negedge ref_clk);
      wait_lvl(1'b0, 1'b0, k);
      rises(9000, k, p);
      chk_num("burst stop", k, 0, 0);
      chk_bit("burst flag", stat_a.burst_stop, 1'b1);
      @(posedge ref_clk);
      fb <= 13'h09C4;
      rises(8100, k, p);
      chk_num("burst resume", k, 1, 3);
      $display("test done: burst");
      // Fault pin pulled to disable in mid-pulse
      next_rise(1'b0);
      @(posedge ref_clk);
      cmp.flt_below_dis <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk_bit("disable stop", gate_a, 1'b0);
      chk_bit("disable flag", stat_a.disabled, 1'b1);
      rises(3200, k, p);
      chk_num("disabled", k, 0, 0);
      @(posedge ref_clk);
      cmp.flt_below_dis <= 1'b0;
      rises(3100, k, p);
      chk_num("leave disable", k, 1, 2);
      $display("test done: disable");
      // One short line dip, then a sustained brown-out inside one pulse
      next_rise(1'b0);
      for (k = 0; k < 33; k++) begin
         @(posedge ref_clk);
         cmp.flt_below_bo <= (k < 15 || k >= 18);
      end
      @(negedge ref_clk);
      chk_bit("short dips", gate_a, 1'b1);
      repeat (26) @(negedge ref_clk);
      chk_bit("brownout stop", gate_a, 1'b0);
      chk_bit("brownout flag", stat_a.brownout, 1'b1);
      @(posedge ref_clk);
      cmp.flt_below_bo <= 1'b0;
      rises(3100, k, p);
      chk_num("brown-in", k, 1, 2);
      $display("test done: brown-out");
      // Overvoltage on the fault pin, only the second variant reacts
      @(posedge ref_clk);
      fb <= 13'h0DAC;
      next_rise(1'b1);
      @(posedge ref_clk);
      cmp.flt_above_ovp <= 1'b1;
      rises(6200, k, p);
      chk_num("ovp qualify", p, 2, 2);
      chk_num("ovp other variant", k, 3, 5);
      $display("test done: overvoltage pin");
      // Shorted output caught during blanking
      next_rise(1'b0);
      wait_lvl(1'b0, 1'b0, k);
      @(posedge ref_clk);
      short_en <= 1'b1;
      rises(15400, k, p);
      chk_num("short pulses", k, 8, 8);
      chk_bit("short fault", stat_a.fault, 1'b1);
      // Supply drop ends the fault, new start-up resumes switching
      @(posedge ref_clk);
      cmp.vdd_above_on <= 1'b0;
      cmp.vdd_below_off <= 1'b1;
      cmp.flt_above_ovp <= 1'b0;
      short_en <= 1'b0;
      repeat (6) @(negedge ref_clk);
      chk_bit("undervoltage stop", stat_a.running, 1'b0);
      chk_bit("fault cleared", stat_a.fault, 1'b0);
      @(posedge ref_clk);
      cmp.vdd_above_on <= 1'b1;
      cmp.vdd_below_off <= 1'b0;
      rises(9000, k, p);
      chk_num("restart", k, 1, 4);
      chk_num("restart other", p, 1, 4);
      $display("test done: fault and restart");
      stop_test();
   end
endmodule
`default_nettype wire

//--- test/fpwm_plant.sv
// Power stage model: switch current ramp seen on the sense resistor
`timescale 1ns/10ps
`default_nettype none
module fpwm_plant
   import fpwm_pkg::*;
#(
   parameter int SLOPE_MV = 10
) (
   // Clock
   input wire logic ref_clk,
   // Gate from the controller and shorted-output request
   input wire logic gate,
   input wire logic short_en,
   // Sense voltage in mV
   output logic [MV_W-1:0] cs_mv
);
   // ==========================================================
   // On-time counter; current collapses as soon as the switch opens
   logic [9:0] on_q;
   always_ff @(posedge ref_clk) begin
      on_q <= gate ? on_q + 10'h001 : 10'h000;
   end

   // Shorted output jumps above the limit right at turn-on
   assign cs_mv = (short_en && gate) ? 13'h03E8 : 13'(on_q * SLOPE_MV);
endmodule
`default_nettype wire
